// ===== verilog/psp_host_port.sv
// parallel slave port: host pins, 16-byte fifo, apb register file, busy/run interrupt
// assumes host strobes are asynchronous; data and address are stable while strobes are low
//
// Overview of operation
// - port ignores the host until the interface enable bit is set
// - while enabled, shared pins are inputs with pull-ups off
// - host uses 8-bit data, address line, read, write strobes, chip select
// - host traffic goes through a 16-byte fifo with interrupt capability
// - host read at address 1 returns host status: busy plus software code
// - host write at address 1 pushes the byte into the fifo
// - host read at address 0 pops the next fifo byte filled by the cpu
// - host write at address 0 pushes the byte for the cpu to consume
// - write data is sampled 1 to 8 clocks after the write strobe start is detected
// - first host byte at address 1 sets the processing busy flag
// - software clears busy; host-visible busy follows it low
// - software-loaded status code is returned on later host status reads
// - firmware checks the fifo empty flag before each data read
// - cpu transfers move byte by byte under a software handshake
// - software may clear busy as soon as the far peripheral is ready
// - host write to full or read from empty fifo sets the run flag
// - on overrun the host byte is dropped, fifo untouched
// - on underrun the host read repeats the previous byte
// - enabled busy or run flag with global enable raises the interrupt
// - software can set and clear the processing busy flag directly
// - host-visible busy reads 0 to software and ignores writes
// - seven low host status bits are a software status code
// - ready flag sets when a byte awaits the host, clears at read end

module psp_host_port (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [psp_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // host pins
  input wire logic host_cs_n,
  input wire logic host_read_strobe_n,
  input wire logic host_write_strobe_n,
  input wire logic host_address_line,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe_n,
  // pin configuration
  output logic pin_input_mode,
  output logic pin_pullup_off,
  // interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // register decode

  function automatic logic reg_hit(input logic [psp_pkg::ADDR_W-1:0] a, input logic [9:0] idx);
    reg_hit = (a[1:0] == 2'h0) && (a[psp_pkg::ADDR_W-1:2] == idx);
  endfunction

  logic [7:0] control;
  logic global_irq_en;
  logic [6:0] host_status_code;
  logic busy;
  logic run_err;
  logic ready;

  wire setup_phase = psel & ~penable;
  wire access_done = psel & penable & pready;
  wire hit_ien = reg_hit(paddr, psp_pkg::IDX_IRQ_ENABLE);
  wire hit_hst = reg_hit(paddr, psp_pkg::IDX_HOST_STATUS);
  wire hit_ctl = reg_hit(paddr, psp_pkg::IDX_CONTROL);
  wire hit_sta = reg_hit(paddr, psp_pkg::IDX_STATUS);
  wire hit_dat = reg_hit(paddr, psp_pkg::IDX_DATA);
  wire hit_any = hit_ien | hit_hst | hit_ctl | hit_sta | hit_dat;
  wire wr_ien = access_done & pwrite & hit_ien;
  wire wr_hst = access_done & pwrite & hit_hst;
  wire wr_ctl = access_done & pwrite & hit_ctl;
  wire wr_sta = access_done & pwrite & hit_sta;
  wire wr_dat = access_done & pwrite & hit_dat;
  wire rd_dat = access_done & ~pwrite & hit_dat;

  wire enabled = control[psp_pkg::CTL_ENABLE];
  wire [2:0] write_sample_delay = control[psp_pkg::CTL_WS_MSB:psp_pkg::CTL_WS_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // host strobe synchronisers

  // async inputs: only the second stage is looked at
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  wire [2:0] raw_in = {host_cs_n, host_read_strobe_n, host_write_strobe_n};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync_a[gi] <= 1'b1;
          sync_b[gi] <= 1'b1;
        end else begin
          sync_a[gi] <= raw_in[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  logic rd_prev;
  logic wr_prev;
  wire rd_act = ~sync_b[2] & ~sync_b[1] & enabled;
  wire wr_act = ~sync_b[2] & ~sync_b[0] & enabled;
  wire rd_start = rd_act & ~rd_prev;
  wire rd_end = ~rd_act & rd_prev;
  wire wr_start = wr_act & ~wr_prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_prev <= 1'b0;
      wr_prev <= 1'b0;
    end else begin
      rd_prev <= rd_act;
      wr_prev <= wr_act;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fifo

  logic [7:0] mem [psp_pkg::DEPTH];
  logic [psp_pkg::PTR_W-1:0] wptr;
  logic [psp_pkg::PTR_W-1:0] rptr;
  logic [psp_pkg::PTR_W:0] count;

  wire fifo_empty = (count == 5'h00);
  wire fifo_full = (count == 5'h10);

  // host write sampling
  psp_pkg::psp_wr_state_t wr_state;
  psp_pkg::psp_wr_state_t next_wr_state;
  logic [2:0] wr_cnt;
  logic wr_addr;
  logic rd_addr;

  wire sample_now = (wr_state == psp_pkg::PSP_WR_WAIT) && wr_act && (wr_cnt == write_sample_delay);
  wire host_push = sample_now & ~fifo_full;
  wire host_overrun = sample_now & fifo_full;
  wire host_pop = rd_start & ~host_address_line & ~fifo_empty;
  wire host_underrun = rd_start & ~host_address_line & fifo_empty;
  // head seen at setup; a byte that lands or leaves after it is never popped unseen
  logic rd_head_ok;
  // host wins a same-cycle clash; the cpu access is dropped, firmware handshakes anyway
  wire cpu_push = wr_dat & ~fifo_full & ~host_push & enabled;
  wire cpu_pop = rd_dat & rd_head_ok & ~host_pop & enabled;
  wire push = host_push | cpu_push;
  wire pop = host_pop | cpu_pop;
  wire [7:0] push_data = host_push ? host_data_in : pwdata[7:0];

  wire [psp_pkg::PTR_W:0] next_count = count + {4'h0, push} - {4'h0, pop};

  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wptr] <= push_data;
    end
  end

  // disabling flushes the fifo, so a re-enabled port always starts empty
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr <= 4'h0;
      rptr <= 4'h0;
      count <= 5'h00;
    end else if (!enabled) begin
      wptr <= 4'h0;
      rptr <= 4'h0;
      count <= 5'h00;
    end else begin
      wptr <= wptr + {3'h0, push};
      rptr <= rptr + {3'h0, pop};
      count <= next_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // host write sequencer

  always_comb begin
    next_wr_state = wr_state;
    case (wr_state)
      psp_pkg::PSP_WR_IDLE: begin
        if (wr_start) begin
          next_wr_state = psp_pkg::PSP_WR_WAIT;
        end
      end
      psp_pkg::PSP_WR_WAIT: begin
        // a strobe released before the sample point drops the byte
        if (!wr_act) begin
          next_wr_state = psp_pkg::PSP_WR_IDLE;
        end else if (sample_now) begin
          next_wr_state = psp_pkg::PSP_WR_HOLD;
        end
      end
      psp_pkg::PSP_WR_HOLD: begin
        if (!wr_act) begin
          next_wr_state = psp_pkg::PSP_WR_IDLE;
        end
      end
      default: begin
        next_wr_state = psp_pkg::PSP_WR_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_state <= psp_pkg::PSP_WR_IDLE;
      wr_cnt <= 3'h0;
      wr_addr <= 1'b0;
    end else begin
      wr_state <= next_wr_state;
      if (wr_start) begin
        wr_cnt <= 3'h0;
        wr_addr <= host_address_line;
      end else if (wr_state == psp_pkg::PSP_WR_WAIT) begin
        // counting starts at the start edge, so a delay of 0 samples one clock later
        wr_cnt <= wr_cnt + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // host read path

  wire [7:0] host_status_word = {busy, host_status_code};

  // underrun repeats the last fifo byte, not a status word read in between
  logic [7:0] last_data;
  wire [7:0] host_read_byte = host_address_line ? host_status_word :
                              fifo_empty ? last_data : mem[rptr];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_data_out <= 8'h00;
      host_data_oe_n <= 1'b1;
      rd_addr <= 1'b0;
      last_data <= 8'h00;
    end else begin
      host_data_oe_n <= ~rd_act;
      if (rd_start) begin
        rd_addr <= host_address_line;
        host_data_out <= host_read_byte;
      end
      if (host_pop) begin
        last_data <= mem[rptr];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags

  // first host byte at address 1 marks the device busy; set beats software clear
  wire busy_set = host_push & wr_addr;
  wire busy_sw_set = wr_sta & pwdata[psp_pkg::STA_BUSY];
  wire busy_sw_clr = wr_sta & ~pwdata[psp_pkg::STA_BUSY];
  wire run_set = host_overrun | host_underrun;
  wire run_clr = wr_sta & ~pwdata[psp_pkg::STA_RUN];
  wire ready_clr = rd_end & ~rd_addr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      run_err <= 1'b0;
      ready <= 1'b0;
    end else begin
      busy <= busy_set | busy_sw_set | (busy & ~busy_sw_clr);
      run_err <= run_set | (run_err & ~run_clr);
      ready <= cpu_push | (ready & ~ready_clr);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers

  logic [7:0] next_control;

  always_comb begin
    next_control = 8'h00;
    next_control[psp_pkg::CTL_ENABLE] = pwdata[psp_pkg::CTL_ENABLE];
    next_control[psp_pkg::CTL_BUSY_IE] = pwdata[psp_pkg::CTL_BUSY_IE];
    next_control[psp_pkg::CTL_RUN_IE] = pwdata[psp_pkg::CTL_RUN_IE];
    next_control[psp_pkg::CTL_WS_MSB:psp_pkg::CTL_WS_LSB] = pwdata[psp_pkg::CTL_WS_MSB:psp_pkg::CTL_WS_LSB];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control <= psp_pkg::RST_CONTROL;
      global_irq_en <= 1'b0;
      host_status_code <= psp_pkg::RST_STATUS_CODE;
    end else begin
      if (wr_ctl) begin
        control <= next_control;
      end
      if (wr_ien) begin
        global_irq_en <= pwdata[psp_pkg::IEN_GLOBAL];
      end
      if (wr_hst) begin
        host_status_code <= pwdata[6:0];
      end
    end
  end

  // reserved bits read 0; the empty bit is what firmware paces its data reads on
  logic [7:0] status_word;
  always_comb begin
    status_word = 8'h00;
    status_word[psp_pkg::STA_EMPTY] = fifo_empty;
    status_word[psp_pkg::STA_BUSY] = busy;
    status_word[psp_pkg::STA_RUN] = run_err;
    status_word[psp_pkg::STA_READY] = ready;
  end
  wire [7:0] read_mux = hit_ien ? {7'h00, global_irq_en} :
                        hit_hst ? {1'b0, host_status_code} :
                        hit_ctl ? control :
                        hit_sta ? status_word :
                        hit_dat ? mem[rptr] : 8'h00;

  // one wait-free access: answer is prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      rd_head_ok <= 1'b0;
    end else begin
      pready <= setup_phase;
      pslverr <= setup_phase & ~hit_any;
      if (setup_phase) begin
        prdata <= {24'h00_0000, read_mux};
        rd_head_ok <= ~fifo_empty & ~host_pop;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins and interrupt

  wire irq_src = (busy & control[psp_pkg::CTL_BUSY_IE]) | (run_err & control[psp_pkg::CTL_RUN_IE]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_input_mode <= 1'b0;
      pin_pullup_off <= 1'b0;
    end else begin
      pin_input_mode <= enabled;
      pin_pullup_off <= enabled;
    end
  end

  // a level, not a pulse: the request drops only when firmware clears a flag or an enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= global_irq_en & irq_src;
    end
  end

endmodule // psp_host_port

// ===== shared/psp_pkg.sv
// package for the parallel slave host port: register map, fields, reset values
// assumes a 32-bit apb master with 12-bit byte addresses
package psp_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DEPTH = 16;
  localparam int unsigned PTR_W = 4;

  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_IRQ_ENABLE = 10'h0a8;
  localparam logic [9:0] IDX_HOST_STATUS = 10'h0ac;
  localparam logic [9:0] IDX_CONTROL = 10'h0ad;
  localparam logic [9:0] IDX_STATUS = 10'h0ae;
  localparam logic [9:0] IDX_DATA = 10'h0af;

  // port_control_register fields
  localparam int unsigned CTL_ENABLE = 7;
  localparam int unsigned CTL_BUSY_IE = 6;
  localparam int unsigned CTL_RUN_IE = 5;
  localparam int unsigned CTL_WS_LSB = 2;
  localparam int unsigned CTL_WS_MSB = 4;

  // port_status_register fields
  localparam int unsigned STA_EMPTY = 7;
  localparam int unsigned STA_BUSY = 6;
  localparam int unsigned STA_RUN = 5;
  localparam int unsigned STA_READY = 4;

  // host_status_register fields
  localparam int unsigned HST_BUSY = 7;

  // interrupt_enable_register_one field
  localparam int unsigned IEN_GLOBAL = 0;

  // reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [6:0] RST_STATUS_CODE = 7'h00;
  localparam logic [7:0] RST_STATUS = 8'h80;

  typedef enum logic [1:0] {
    PSP_WR_IDLE,
    PSP_WR_WAIT,
    PSP_WR_HOLD
  } psp_wr_state_t;

endpackage

// ===== testbench/psp_host_port_monitor.sv
// checker for psp_host_port: apb answer, host data driving, pin mode, interrupt cause
// assumes one pclk domain and host strobes held as long as the host model holds them
module psp_host_port_monitor (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // host pins
  input wire logic host_cs_n,
  input wire logic host_read_strobe_n,
  input wire logic host_write_strobe_n,
  input wire logic [7:0] host_data_out,
  input wire logic host_data_oe_n,
  // pin mode and interrupt
  input wire logic pin_input_mode,
  input wire logic pin_pullup_off,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_setup; psel && !penable; endsequence
  sequence s_rd_idle; host_read_strobe_n [*5]; endsequence
  property p_answer; s_setup |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("no apb answer");
  property p_once; pready |=> !pready; endproperty
  a_once: assert property (p_once) else $error("pready held");
  // pins only move two edges after a completed apb access, the control write
  property p_pins; (pin_input_mode == pin_pullup_off)
    && (!$changed(pin_input_mode) || $past(psel && penable && pready, 2)); endproperty
  a_pins: assert property (p_pins) else $error("pin mode split");
  property p_quiet; !pin_input_mode |-> host_data_oe_n; endproperty
  a_quiet: assert property (p_quiet) else $error("drive while off");
  // two sync flops sit between the pin and the start detector
  property p_oe_cause; $fell(host_data_oe_n) |-> $past(!host_read_strobe_n && !host_cs_n, 2); endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("drive without read");
  property p_oe_end; s_rd_idle |-> host_data_oe_n; endproperty
  a_oe_end: assert property (p_oe_end) else $error("drive after read");
  property p_hold; !host_data_oe_n && $past(!host_data_oe_n) |-> $stable(host_data_out); endproperty
  a_hold: assert property (p_hold) else $error("data moved");
  property p_irq; $rose(irq) |-> $past(pready) || $past(pready, 2) || $past(pready, 3)
    || !host_write_strobe_n || !host_read_strobe_n; endproperty
  a_irq: assert property (p_irq) else $error("irq without cause");
endmodule // psp_host_port_monitor

bind psp_host_port psp_host_port_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .host_cs_n(host_cs_n), .host_read_strobe_n(host_read_strobe_n),
  .host_write_strobe_n(host_write_strobe_n), .host_data_out(host_data_out),
  .host_data_oe_n(host_data_oe_n), .pin_input_mode(pin_input_mode), .pin_pullup_off(pin_pullup_off),
  .irq(irq));

// ===== testbench/psp_host_model.sv
// host processor model: chip select, strobes, address line and write data
// assumes pclk only paces the strobes; the device treats them as asynchronous
module psp_host_model (
  // pacing clock
  input wire logic pclk,
  // host pins
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic addr,
  output logic [7:0] din,
  input wire logic [7:0] dout,
  input wire logic oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = 1'b0;
    din = 8'h5a;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // strobes stay low well past the widest sampling delay; slow, but never outruns the port
  task automatic xfer(input logic rd, input logic a, input logic [7:0] d, output logic [7:0] q);
    @(posedge pclk);
    cs_n <= 1'b0;
    addr <= a;
    din <= rd ? ~din : d;
    rd_n <= ~rd;
    wr_n <= rd;
    repeat (rd ? 8 : 14) @(posedge pclk);
    // an undriven bus reads back inverted, so a missing drive never passes
    q = oe_n ? ~dout : dout;
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    din <= ~din;
    addr <= ~a;
    repeat (5) @(posedge pclk);
  endtask
endmodule // psp_host_model

// ===== testbench/psp_host_port_bench.sv
// self-checking bench for psp_host_port through apb and the host model
// assumes psp_pkg, the host model and the monitor bind are compiled first
module psp_host_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
  localparam logic [9:0] I_ST = psp_pkg::IDX_STATUS;
  localparam logic [9:0] I_CT = psp_pkg::IDX_CONTROL;
  localparam logic [9:0] I_HS = psp_pkg::IDX_HOST_STATUS;
  localparam logic [9:0] I_DT = psp_pkg::IDX_DATA;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, cs_n, rd_n, wr_n, ha, oe_n, pim, ppo, irq;
  logic [7:0] hdi, hdo, hb;
  int n_fail = 0;
  int num_checks = 0;
  psp_host_port uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .host_cs_n(cs_n),
    .host_read_strobe_n(rd_n), .host_write_strobe_n(wr_n), .host_address_line(ha), .host_data_in(hdi),
    .host_data_out(hdo), .host_data_oe_n(oe_n), .pin_input_mode(pim), .pin_pullup_off(ppo), .irq(irq));
  psp_host_model host (.pclk(pclk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(ha), .din(hdi),
    .dout(hdo), .oe_n(oe_n));
  initial begin
    forever #2 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // setup waits one edge so a release and a new request never share a time step
  task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string n, input logic [9:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 32'h0);
    `CHK(n, {24'h0, e}, rd)
  endtask
  task automatic hrd(input string n, input logic a, input logic [7:0] e);
    host.xfer(1'b1, a, 8'h00, hb);
    `CHK(n, e, hb)
  endtask
  task automatic t_reset();
    rchk("status", I_ST, psp_pkg::RST_STATUS);
    rchk("control", I_CT, psp_pkg::RST_CONTROL);
    rchk("unmapped", 10'h000, 8'h00);
    `CHK("slverr", 1'b1, err)
    `CHK("pins", 2'b00, {pim, ppo})
  endtask
  task automatic t_disabled();
    host.xfer(1'b0, 1'b1, 8'h11, hb);
    rchk("status", I_ST, 8'h80);
    hrd("host read", 1'b1, 8'hff);
  endtask
  task automatic t_enable();
    apb(1'b1, I_CT, 32'hff);
    rchk("control", I_CT, 8'hfc);
    `CHK("pins", 2'b11, {pim, ppo})
    apb(1'b1, psp_pkg::IDX_IRQ_ENABLE, 32'h1);
    apb(1'b1, I_HS, 32'hd5);
    rchk("code", I_HS, 8'h55);
    hrd("host status", 1'b1, 8'h55);
  endtask
  task automatic t_busy();
    host.xfer(1'b0, 1'b1, 8'ha5, hb);
    rchk("status", I_ST, 8'h40);
    `CHK("irq", 1'b1, irq)
    hrd("host busy", 1'b1, 8'hd5);
    rchk("data", I_DT, 8'ha5);
    apb(1'b1, I_ST, 32'h0);
    rchk("status", I_ST, 8'h80);
    `CHK("irq", 1'b0, irq)
    hrd("host idle", 1'b1, 8'h55);
  endtask
  task automatic t_overrun();
    for (int i = 0; i < 17; i++) begin
      host.xfer(1'b0, 1'b0, 8'(32 + i), hb);
    end
    rchk("status", I_ST, 8'h20);
    `CHK("irq", 1'b1, irq)
    for (int i = 0; i < 16; i++) begin
      rchk("fifo", I_DT, 8'(32 + i));
    end
    apb(1'b1, I_ST, 32'h0);
    rchk("status", I_ST, 8'h80);
  endtask
  task automatic t_underrun();
    apb(1'b1, I_DT, 32'h3c);
    rchk("status", I_ST, 8'h10);
    hrd("host data", 1'b0, 8'h3c);
    rchk("status", I_ST, 8'h80);
    hrd("host status", 1'b1, 8'h55);
    hrd("host repeat", 1'b0, 8'h3c);
    rchk("status", I_ST, 8'ha0);
    `CHK("irq", 1'b1, irq)
    apb(1'b1, psp_pkg::IDX_IRQ_ENABLE, 32'h0);
    rchk("global", psp_pkg::IDX_IRQ_ENABLE, 8'h00);
    `CHK("irq", 1'b0, irq)
  endtask
  task automatic t_delay0();
    apb(1'b1, I_ST, 32'h0);
    apb(1'b1, I_CT, 32'h80);
    host.xfer(1'b0, 1'b0, 8'h77, hb);
    rchk("data", I_DT, 8'h77);
    apb(1'b1, I_CT, 32'h0);
    rchk("status", I_ST, 8'h80);
    `CHK("pins", 2'b00, {pim, ppo})
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_disabled();
    t_enable();
    t_busy();
    t_overrun();
    t_underrun();
    t_delay0();
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    end_of_test();
  end
endmodule // psp_host_port_bench
